// ### hdl/pin_function_select_and_bus_release.sv
// Pin role selection for bits 25 to 27 and memory bus release on grant.
// Assumes an APB master on pclk and a memory controller that reports idle.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pin_function_select_and_bus_release
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 8                     // APB address width
) (
  input  wire logic              pclk,           // System clock, 250 MHz
  input  wire logic              presetn,        // Async reset, active low
  input  wire logic [ADDR_W-1:0] paddr,          // APB address
  input  wire logic              psel,           // APB select
  input  wire logic              penable,        // APB enable
  input  wire logic              pwrite,         // APB direction
  input  wire logic [DATA_W-1:0] pwdata,         // APB write data
  output logic      [DATA_W-1:0] prdata,         // APB read data
  output logic                   pready,         // APB ready
  output logic                   pslverr,        // APB error, unmapped
  input  wire mem_ctl_s          mem_ctl,        // Controller strobes
  input  wire logic [DATA_W-1:0] mem_data_out,   // Controller write data
  input  wire logic              mem_data_oe,    // Controller drives data
  input  wire logic              mem_idle,       // Controller between cycles
  output logic      [DATA_W-1:0] mem_data_in,    // Registered data pads
  output logic                   bus_granted,    // Bus handed to far master
  input  wire logic              slow_clk_in,    // 32 kHz clock to buffer
  input  wire logic [DATA_W-1:0] data_pin_i,     // Data pad inputs
  output logic      [DATA_W-1:0] data_pin_o,     // Data pad outputs
  output logic                   data_pin_oe,    // Data pad enable
  output mem_ctl_s               ctl_pin_o,      // Strobe pad outputs
  output logic                   ctl_pin_oe,     // Strobe pad enable
  input  wire logic [NUM_MUX-1:0] mux_pin_i,     // Pins 25..27 inputs
  output logic      [NUM_MUX-1:0] mux_pin_o,     // Pins 25..27 outputs
  output logic      [NUM_MUX-1:0] mux_pin_oe     // Pins 25..27 enables
);

  localparam logic [ADDR_W-1:0] ALIGN_MASK = ADDR_W'(3);

  logic [DATA_W-1:0] role_q, role_d;
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] gout_q, gout_d;
  logic [DATA_W-1:0] goe_q,  goe_d;
  logic [DATA_W-1:0] prdata_d;
  logic              pready_d;
  logic              pslverr_d;
  logic [DATA_W-1:0] mem_data_in_d;
  logic              grant_q, grant_d;
  logic              setup_ph;
  logic              wr_commit;
  logic              mapped;
  logic [DATA_W-1:0] gin_word;
  logic [DATA_W-1:0] stat_word;
  logic              req_active;
  logic [NUM_MUX-1:0] std_in;
  logic [NUM_MUX-1:0] gpio_in;
  pin_drive_s        drv [NUM_MUX];
  logic [MEM_CTL_W-1:0] ctl_bits;

  // Address decode; misaligned addresses count as unmapped
  always_comb begin
    setup_ph  = psel & ~penable;
    wr_commit = psel & penable & pready & pwrite;
    mapped    = ((paddr & ALIGN_MASK) == '0) &&
                (paddr[7:0] == OFS_ROLE || paddr[7:0] == OFS_CTRL ||
                 paddr[7:0] == OFS_GOUT || paddr[7:0] == OFS_GOE  ||
                 paddr[7:0] == OFS_GIN  || paddr[7:0] == OFS_STAT);
  end

  // Pin levels and state visible to software; unused bits read zero
  always_comb begin
    gin_word  = '0;
    stat_word = '0;
    gin_word[MUX_BASE +: NUM_MUX] = gpio_in;
    stat_word[STAT_GRANT] = grant_q;
    stat_word[STAT_REQ]   = req_active;
  end

  // Register file next state; a write lands at the access edge only
  always_comb begin
    role_d = role_q;
    ctrl_d = ctrl_q;
    gout_d = gout_q;
    goe_d  = goe_q;
    if (wr_commit && mapped) begin
      case (paddr[7:0])
        OFS_ROLE: role_d = pwdata & MUX_MASK;
        OFS_CTRL: ctrl_d = pwdata & CTRL_MASK;
        OFS_GOUT: gout_d = pwdata & MUX_MASK;
        OFS_GOE:  goe_d  = pwdata & MUX_MASK;
        default: begin
        end
      endcase
    end
  end

  // Read data is prepared in the setup cycle so pready needs no wait state
  always_comb begin
    prdata_d  = '0;
    pready_d  = setup_ph;
    pslverr_d = setup_ph & ~mapped;
    if (setup_ph && !pwrite && mapped) begin
      case (paddr[7:0])
        OFS_ROLE: prdata_d = role_q;
        OFS_CTRL: prdata_d = ctrl_q;
        OFS_GOUT: prdata_d = gout_q;
        OFS_GOE:  prdata_d = goe_q;
        OFS_GIN:  prdata_d = gin_word;
        OFS_STAT: prdata_d = stat_word;
        default:  prdata_d = '0;
      endcase
    end
  end

  // Register file and bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_q  <= ROLE_SEL_RST;
      ctrl_q  <= CTRL_RST;
      gout_q  <= '0;
      goe_q   <= '0;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      role_q  <= role_d;
      ctrl_q  <= ctrl_d;
      gout_q  <= gout_d;
      goe_q   <= goe_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Standard and general I/O drive for each multiplexed pin
  always_comb begin
    for (int i = 0; i < NUM_MUX; i++) begin
      drv[i].gpio_out = gout_q[MUX_BASE + i];
      drv[i].gpio_oe  = goe_q[MUX_BASE + i];
    end
    drv[IDX_SLOW].std_out  = slow_clk_in;
    drv[IDX_SLOW].std_oe   = 1'b1;
    drv[IDX_GRANT].std_out = ~grant_d;
    drv[IDX_GRANT].std_oe  = 1'b1;
    drv[IDX_REQ].std_out   = 1'b1;
    drv[IDX_REQ].std_oe    = 1'b0;                   // Request is an input
  end

  genvar g;
  generate
    for (g = 0; g < NUM_MUX; g++) begin : g_mux
      pin_role_cell #(
        .STD_IDLE (1'b1)
      ) u_cell (
        .clk      (pclk),
        .rst_n    (presetn),
        .role_sel (role_q[MUX_BASE + g]),
        .drv      (drv[g]),
        .pin_i    (mux_pin_i[g]),
        .pin_o    (mux_pin_o[g]),
        .pin_oe   (mux_pin_oe[g]),
        .std_in   (std_in[g]),
        .gpio_in  (gpio_in[g])
      );
    end
  endgenerate

  // Arbitration: grant only when both pins are in standard role.
  // A new grant waits for the controller to be idle so no cycle is cut.
  always_comb begin
    req_active = ~std_in[IDX_REQ];
    grant_d = req_active &&
              !role_q[MUX_BASE + IDX_REQ] &&
              !role_q[MUX_BASE + IDX_GRANT] &&
              (grant_q || (ctrl_q[CTRL_ARB_EN] && mem_idle));
    mem_data_in_d = data_pin_i;
  end

  // Grant state and captured data pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q     <= 1'b0;
      bus_granted <= 1'b0;
      mem_data_in <= '0;
    end else begin
      grant_q     <= grant_d;
      bus_granted <= grant_d;
      mem_data_in <= mem_data_in_d;
    end
  end

  // Memory bus output stages float together with the grant edge
  bus_release_gate #(
    .W (DATA_W)
  ) u_data_gate (
    .clk       (pclk),
    .rst_n     (presetn),
    .val       (mem_data_out),
    .oe_req    (mem_data_oe),
    .release_d (grant_d),
    .pin_o     (data_pin_o),
    .pin_oe    (data_pin_oe)
  );

  bus_release_gate #(
    .W (MEM_CTL_W)
  ) u_ctl_gate (
    .clk       (pclk),
    .rst_n     (presetn),
    .val       (mem_ctl),
    .oe_req    (1'b1),
    .release_d (grant_d),
    .pin_o     (ctl_bits),
    .pin_oe    (ctl_pin_oe)
  );

  // Strobe group regains its struct shape at the pads
  assign ctl_pin_o = mem_ctl_s'(ctl_bits);

  // While granted, no memory bus pad is driven
  grant_hiz_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    grant_q |-> (!ctl_pin_oe && !data_pin_oe))
    else $error("memory bus driven while granted");

  // Strobes are driven whenever the bus is ours after reset
  own_bus_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!grant_q && $past(presetn)) |-> ctl_pin_oe)
    else $error("strobes floated without a grant");

  // A grant rises only in answer to a request
  grant_cause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(grant_q) |-> $past(req_active) && $past(mem_idle))
    else $error("grant raised without request");

  // Grant pad shows the grant in the same cycle
  grant_pin_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (grant_q && !role_q[MUX_BASE + IDX_GRANT])
      |-> (!mux_pin_o[IDX_GRANT] && mux_pin_oe[IDX_GRANT]))
    else $error("grant pad not low while granted");

  // Dropping the request ends the grant and drives the strobes again
  // at the same edge; a regrant may follow at once, so look no further
  grant_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (grant_q && !req_active) |=> (!grant_q && ctl_pin_oe))
    else $error("grant held after request left");

  // Reset leaves the slow clock pin in I/O role, bus pins standard
  role_reset_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> (role_q == ROLE_SEL_RST))
    else $error("role select reset value wrong");

  // In I/O role the pad follows the general output register
  role_route_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(role_q[MUX_BASE + IDX_SLOW]) && $past(presetn))
      |-> (mux_pin_o[IDX_SLOW] == $past(gout_q[MUX_BASE + IDX_SLOW])))
    else $error("slow clock pad not routed to general output");

  // In standard role the slow clock pad follows its source
  slow_std_route_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!$past(role_q[MUX_BASE + IDX_SLOW]) && $past(presetn))
      |-> (mux_pin_o[IDX_SLOW] == $past(slow_clk_in)))
    else $error("slow clock pad not routed to its source");

  // Grant pad in I/O role takes its enable from the general register
  grant_io_route_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(role_q[MUX_BASE + IDX_GRANT]) && $past(presetn))
      |-> (mux_pin_oe[IDX_GRANT] == $past(goe_q[MUX_BASE + IDX_GRANT])))
    else $error("grant pad enable not from general register");

  // Request pad is an input in standard role, never driven
  req_pin_input_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!$past(role_q[MUX_BASE + IDX_REQ]) && $past(presetn))
      |-> !mux_pin_oe[IDX_REQ])
    else $error("request pad driven in standard role");

  // Reserved pins own no storage bits at all
  reserved_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (((role_q | gout_q | goe_q) & ~MUX_MASK) == '0))
    else $error("reserved pin bit holds a value");

  // Either arbitration pin in I/O role blocks the grant
  io_role_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (role_q[MUX_BASE + IDX_REQ] || role_q[MUX_BASE + IDX_GRANT])
      |=> !grant_q)
    else $error("grant given with a pin in I/O role");

  // With arbitration disabled no new grant starts
  arb_off_block_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!grant_q && !ctrl_q[CTRL_ARB_EN]) |=> !grant_q)
    else $error("grant started while arbitration off");

  // Role writes keep only the implemented pin bits
  role_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_commit && paddr[7:0] == OFS_ROLE)
      |=> (role_q == ($past(pwdata) & MUX_MASK)))
    else $error("role write not stored or reserved bit kept");

endmodule // pin_function_select_and_bus_release

// ### hdl/pin_mux_pkg.sv
// Constants, field layouts and carrier types for the pin selection block.
// Assumes an APB master with 32-bit data and a memory controller nearby.
// How it works
// - Select bit one picks general I/O role
// - Request/grant select reset 0, slow clock 1
// - Grant asserted floats all memory bus outputs
// - Request first, grant next, release with grant
// - Reserved pins get no logic at all
package pin_mux_pkg;

  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_ROLE = 8'h00; // pin_role_select
  localparam logic [7:0] OFS_CTRL = 8'h04; // arbitration control
  localparam logic [7:0] OFS_GOUT = 8'h08; // general I/O output values
  localparam logic [7:0] OFS_GOE  = 8'h0C; // general I/O output enables
  localparam logic [7:0] OFS_GIN  = 8'h10; // general I/O pin levels
  localparam logic [7:0] OFS_STAT = 8'h14; // arbitration status

  // Multiplexed pins handled here, general I/O bits 25 to 27
  localparam int MUX_BASE  = 25;
  localparam int NUM_MUX   = 3;
  localparam int IDX_SLOW  = 0;  // buffered_slow_clock_out, bit 25
  localparam int IDX_GRANT = 1;  // bus_grant_n, bit 26
  localparam int IDX_REQ   = 2;  // bus_request_n, bit 27

  localparam logic [31:0] ROLE_SEL_RST = 32'h0200_0000;
  localparam logic [31:0] MUX_MASK     = 32'h0E00_0000;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0001;
  localparam int CTRL_ARB_EN  = 0;
  localparam int STAT_GRANT   = 0;
  localparam int STAT_REQ     = 1;

  // Memory interface strobes released during bus arbitration
  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] col_strobe_n;
    logic [1:0] row_strobe_n;
    logic       mem_chip_sel0_n;
    logic       mem_clk_en;
    logic       mem_clk_out;
    logic       upper_byte_mask;
    logic       lower_byte_mask;
  } mem_ctl_s;

  localparam int MEM_CTL_W = $bits(mem_ctl_s);

  // One multiplexed pin as seen from the functions behind it
  typedef struct packed {
    logic std_out;
    logic std_oe;
    logic gpio_out;
    logic gpio_oe;
  } pin_drive_s;

endpackage

// ### hdl/pin_role_cell.sv
// One multiplexed pin: steers pad drive between standard and general I/O.
// Assumes the pad input is synchronous to pclk.
`timescale 1ns/1ps
module pin_role_cell
  import pin_mux_pkg::*;
#(
  parameter logic STD_IDLE = 1'b1    // Standard input level in I/O role
) (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Asynchronous reset, active low
  input  wire logic       role_sel,  // 1 = general I/O role, 0 = standard
  input  wire pin_drive_s drv,       // Drive requests from both functions
  input  wire logic       pin_i,     // Pad input level
  output logic            pin_o,     // Pad output value
  output logic            pin_oe,    // Pad output enable, high drives
  output logic            std_in,    // Input seen by the standard function
  output logic            gpio_in    // Input seen by general I/O
);

  logic pin_o_d;
  logic pin_oe_d;

  // Select the owner of the pad
  always_comb begin
    pin_o_d  = role_sel ? drv.gpio_out : drv.std_out;
    pin_oe_d = role_sel ? drv.gpio_oe  : drv.std_oe;
    std_in   = role_sel ? STD_IDLE : pin_i;
    gpio_in  = pin_i;
  end

  // Pad drive is registered so the pin is glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o  <= 1'b1;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= pin_o_d;
      pin_oe <= pin_oe_d;
    end
  end

endmodule // pin_role_cell

// ### hdl/bus_release_gate.sv
// Registered output stage that floats a group of bus pins on request.
// Assumes the release input is the next-cycle grant state.
`timescale 1ns/1ps
module bus_release_gate #(
  parameter int W = 32                  // Width of the pin group
) (
  input  wire logic         clk,        // System clock
  input  wire logic         rst_n,      // Asynchronous reset, active low
  input  wire logic [W-1:0] val,        // Values from the memory controller
  input  wire logic         oe_req,     // Controller wants to drive
  input  wire logic         release_d,  // Float the group from next edge
  output logic      [W-1:0] pin_o,      // Pad output values
  output logic              pin_oe      // Pad output enable, high drives
);

  logic [W-1:0] pin_o_d;
  logic         pin_oe_d;

  // Release overrides any drive request
  always_comb begin
    pin_o_d  = val;
    pin_oe_d = oe_req & ~release_d;
  end

  // Same edge as the grant flop, so no cycle of overlap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o  <= '0;
      pin_oe <= 1'b0;
    end else begin
      pin_o  <= pin_o_d;
      pin_oe <= pin_oe_d;
    end
  end

endmodule // bus_release_gate

// ### verification/bus_master_model.sv
// Model of the external master that borrows the memory bus.
// Assumes request and grant pins are synchronous to clk, active low.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic  clk,      // System clock
  input  wire logic  rst_n,    // Async reset, active low
  input  wire logic  want,     // Bench asks for a bus tenure
  input  wire logic  grant_n,  // Grant pin level
  output logic        req_n,    // Request pin drive
  output logic        owns_bus, // Bus taken, grant seen
  output logic [31:0] ext_data  // Data this master puts on the bus
);
  logic req_n_d;
  logic tog_q;
  logic tog_d;

  // Request follows the bench; no other handshake exists on this link
  always_comb begin
    req_n_d = !want;
    tog_d   = !tog_q;
  end

  // Registered so the pin changes just after a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_n <= 1'b1;
      tog_q <= 1'b0;
    end else begin
      req_n <= req_n_d;
      tog_q <= tog_d;
    end
  end

  // Drives data only once granted; otherwise a toggling value, so a
  // stale level can never be taken for a good capture
  assign owns_bus = !req_n && !grant_n;
  assign ext_data = owns_bus ? 32'hC3C3_3C3C : {32{tog_q}};
endmodule // bus_master_model

// ### verification/test_pin_function_select_and_bus_release.sv
// Self-checking bench for pin role selection and bus release on grant.
// Assumes the design package and the external master model are compiled.
`timescale 1ns/1ps
module test_pin_function_select_and_bus_release;
  import pin_mux_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0000_0000;
  mem_ctl_s          mem_ctl = 14'h0000;
  logic [31:0]       mem_data_out = 32'h0000_0000;
  logic              mem_data_oe = 1'b0;
  logic              mem_idle = 1'b1;
  logic              slow_clk_in = 1'b0;
  logic              want = 1'b0;
  logic [31:0]       prdata, mem_data_in, data_pin_o, data_pin_i, ext_data;
  logic              pready, pslverr, bus_granted, data_pin_oe, ctl_pin_oe;
  logic              req_n, owns_bus;
  mem_ctl_s          ctl_pin_o;
  logic [2:0]        mux_pin_o, mux_pin_oe, mux_pin_i;
  logic [31:0]       rd;
  logic              err;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #2 pclk = ~pclk;

  // Pad levels: a driving design wins, released pins 25/26 pull high
  assign mux_pin_i[0] = mux_pin_oe[0] ? mux_pin_o[0] : 1'b1;
  assign mux_pin_i[1] = mux_pin_oe[1] ? mux_pin_o[1] : 1'b1;
  assign mux_pin_i[2] = mux_pin_oe[2] ? mux_pin_o[2] : req_n;
  assign data_pin_i   = data_pin_oe ? data_pin_o : ext_data;

  pin_function_select_and_bus_release pin_function_select_and_bus_release_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_ctl(mem_ctl),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
    .mem_idle(mem_idle), .mem_data_in(mem_data_in),
    .bus_granted(bus_granted), .slow_clk_in(slow_clk_in),
    .data_pin_i(data_pin_i), .data_pin_o(data_pin_o),
    .data_pin_oe(data_pin_oe), .ctl_pin_o(ctl_pin_o),
    .ctl_pin_oe(ctl_pin_oe), .mux_pin_i(mux_pin_i),
    .mux_pin_o(mux_pin_o), .mux_pin_oe(mux_pin_oe));

  bus_master_model bus_master_model_i (
    .clk(pclk), .rst_n(presetn), .want(want), .grant_n(mux_pin_i[1]),
    .req_n(req_n), .owns_bus(owns_bus), .ext_data(ext_data));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  task automatic t_reset();
    tick(2);
    chk("grant pin oe", 32'h1, mux_pin_oe[1]);
    chk("grant pin idle", 32'h1, mux_pin_o[1]);
    chk("request pin oe", 32'h0, mux_pin_oe[2]);
    chk("slow pin oe", 32'h0, mux_pin_oe[0]);
    rchk("role reset", OFS_ROLE, 32'h0200_0000);
    chk("mapped err", 32'h0, err);
    rchk("ctrl reset", OFS_CTRL, 32'h0000_0001);
    rchk("pad levels", OFS_GIN, 32'h0E00_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped err", 32'h1, err);
  endtask

  // Pin 25 follows GOUT in I/O role and the slow clock in standard role
  task automatic t_role();
    apb(1'b1, OFS_GOUT, 32'h0200_0000);
    apb(1'b1, OFS_GOE, 32'h0600_0000);
    tick(2);
    chk("io role out", 32'h1, mux_pin_o[0]);
    chk("io role oe", 32'h1, mux_pin_oe[0]);
    slow_clk_in <= 1'b1;
    apb(1'b1, OFS_GOUT, 32'h0000_0000);
    apb(1'b1, OFS_ROLE, 32'h0000_0000);
    tick(3);
    chk("std role high", 32'h1, mux_pin_o[0]);
    slow_clk_in <= 1'b0;
    tick(3);
    chk("std role low", 32'h0, mux_pin_o[0]);
    apb(1'b1, OFS_ROLE, 32'h0400_0000);
    tick(2);
    chk("grant pin io", 32'h0, mux_pin_o[1]);
    apb(1'b1, OFS_GOE, 32'h0000_0000);
  endtask

  // Requests that must be refused: I/O role, controller busy, disabled
  task automatic t_refuse();
    mem_idle <= 1'b0;
    apb(1'b1, OFS_ROLE, 32'hFFFF_FFFF);
    rchk("role mask", OFS_ROLE, MUX_MASK);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    mem_idle <= 1'b1;
    want <= 1'b1;
    tick(6);
    chk("no grant io", 32'h0, bus_granted);
    mem_idle <= 1'b0;
    apb(1'b1, OFS_ROLE, 32'h0000_0000);
    tick(6);
    chk("no grant busy", 32'h0, bus_granted);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    mem_idle <= 1'b1;
    tick(6);
    chk("no grant off", 32'h0, bus_granted);
    chk("strobes kept", 32'h1, ctl_pin_oe);
  endtask

  task automatic t_grant();
    int i;
    mem_ctl <= 14'h1A5A;
    mem_data_out <= 32'h1234_5678;
    mem_data_oe <= 1'b1;
    tick(2);
    chk("strobes driven", 32'h1A5A, ctl_pin_o);
    chk("data driven", 32'h1234_5678, data_pin_o);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    for (i = 0; i < 10 && bus_granted !== 1'b1; i++) tick(1);
    chk("granted", 32'h1, bus_granted);
    chk("grant pin low", 32'h0, mux_pin_o[1]);
    chk("strobes float", 32'h0, ctl_pin_oe);
    chk("data float", 32'h0, data_pin_oe);
    mem_idle <= 1'b0;
    tick(2);
    chk("ext data in", 32'hC3C3_3C3C, mem_data_in);
    rchk("status", OFS_STAT, 32'h0000_0003);
    chk("grant held", 32'h1, owns_bus);
    want <= 1'b0;
    for (i = 0; i < 10 && bus_granted !== 1'b0; i++) tick(1);
    chk("grant pin high", 32'h1, mux_pin_o[1]);
    chk("strobes back", 32'h1, ctl_pin_oe);
    chk("data back", 32'h1, data_pin_oe);
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_role();
    t_refuse();
    t_grant();
    complete_run();
  end
endmodule // test_pin_function_select_and_bus_release
